// >>> hdl/mss_sequencer.sv
`timescale 1ns/1ps
`include "mss_cfg.svh"
module mss_sequencer import mss_pkg::*; #(
  parameter int TICK_CYCLES = `MSS_TICK_CYCLES,
  parameter int AW = 8,
  parameter int SW = 8
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Register port
  input wire logic [AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Sensor front end
  input wire logic [SW-1:0] sensor_level,
  input wire logic sensor_fault,
  // Operator switches
  input wire logic power_enable_switch,
  input wire logic manual_trigger_switch,
  // Valve driver and lamps
  output logic valve_drive,
  output logic marker_found_lamp,
  output logic skip_lamp,
  output logic sensor_fault_lamp
);

  // Holds a written value inside the range lo to hi
  function automatic logic [9:0] clamp10(input logic [31:0] v, input logic [9:0] lo, input logic [9:0] hi);
    logic [9:0] r;
    r = hi;
    if (v < 32'(lo)) begin
      r = lo;
    end else if (v <= 32'(hi)) begin
      r = v[9:0];
    end
    return r;
  endfunction

  // Counters stop at all ones instead of wrapping
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction

  localparam logic [9:0] DELAY_MAX = 10'(`MSS_DELAY_MAX_MS);
  localparam logic [9:0] TRIM_MAX = 10'(`MSS_TRIM_MAX_MS);
  localparam logic [9:0] SKIP_MIN = 10'(`MSS_SKIP_MIN_MS);
  localparam logic [9:0] SKIP_MAX = 10'(`MSS_SKIP_MAX_MS);
  localparam logic [10:0] WARMUP_MS = 11'(`MSS_WARMUP_MS);
  localparam logic [10:0] LAMP_MS = 11'(`MSS_FOUND_LAMP_MS);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  // Settings
  logic [9:0] delay_r;
  logic [9:0] trim_r;
  logic [9:0] skip_r;
  logic [SW-1:0] thresh_r;
  logic soft_trig_r;
  logic [15:0] det_cnt_r;
  logic [15:0] skip_cnt_r;

  // Sequencer
  mss_state_t state_r;
  mss_state_t state_nxt;
  logic [TW-1:0] tick_cnt_r;
  logic tick_r;
  logic hit_prev_r;
  logic man_prev_r;

  // Outputs
  logic valve_r;
  logic found_r;
  logic skip_lamp_r;
  logic fault_r;
  logic [31:0] rdata_r;

  // Register decode
  wire sel_delay = (reg_addr == AW'(`MSS_REG_DELAY));
  wire sel_trim = (reg_addr == AW'(`MSS_REG_TRIM));
  wire sel_skip = (reg_addr == AW'(`MSS_REG_SKIP));
  wire sel_thresh = (reg_addr == AW'(`MSS_REG_THRESH));
  wire sel_ctrl = (reg_addr == AW'(`MSS_REG_CTRL));
  wire sel_status = (reg_addr == AW'(`MSS_REG_STATUS));
  wire sel_detcnt = (reg_addr == AW'(`MSS_REG_DETCNT));
  wire sel_skipcnt = (reg_addr == AW'(`MSS_REG_SKIPCNT));
  wire wr_delay = reg_wr && sel_delay;
  wire wr_trim = reg_wr && sel_trim;
  wire wr_skip = reg_wr && sel_skip;
  wire wr_thresh = reg_wr && sel_thresh;
  wire wr_ctrl = reg_wr && sel_ctrl;
  wire wr_detcnt = reg_wr && sel_detcnt;
  wire wr_skipcnt = reg_wr && sel_skipcnt;

  // Write values are held inside their usable ranges
  wire [9:0] delay_wval = clamp10(reg_wdata, 10'h000, DELAY_MAX);
  wire [9:0] trim_wval = clamp10(reg_wdata, 10'h000, TRIM_MAX);
  wire [9:0] skip_wval = clamp10(reg_wdata, SKIP_MIN, SKIP_MAX);

  // Total delay is coarse plus fine; both at maximum gives 750 ms
  wire [10:0] delay_total = {1'b0, delay_r} + {1'b0, trim_r};

  // Trigger sources
  // Edge history resets low, the idle level of both inputs, so reset makes no false edge
  // A reported sensor fault blocks detections; manual and software triggers still act
  wire pickup_threshold_hit = (sensor_level >= thresh_r);
  wire det_edge = pickup_threshold_hit && !hit_prev_r && !sensor_fault;
  wire man_edge = manual_trigger_switch && !man_prev_r;
  wire trigger = det_edge || man_edge || soft_trig_r;

  // Main timer runs warm-up, delay and skip in turn
  logic main_load;
  logic [10:0] main_val;
  logic main_expire;
  logic lamp_busy;
  logic lamp_expire;

  // A trigger outside IDLE is dropped, never queued
  wire start_cycle = (state_r == MSS_IDLE) && power_enable_switch && trigger;

  // Turning the switch off aborts any cycle; turning it on again repeats the warm-up
  always_comb begin
    state_nxt = state_r;
    main_load = 1'b0;
    main_val = 11'h000;
    unique case (state_r)
      MSS_OFF: begin
        if (power_enable_switch) begin
          state_nxt = MSS_WARMUP;
          main_load = 1'b1;
          main_val = WARMUP_MS;
        end
      end
      MSS_WARMUP: begin
        if (!power_enable_switch) begin
          state_nxt = MSS_OFF;
        end else if (main_expire) begin
          state_nxt = MSS_IDLE;
        end
      end
      MSS_IDLE: begin
        if (!power_enable_switch) begin
          state_nxt = MSS_OFF;
        end else if (start_cycle) begin
          state_nxt = MSS_DELAY;
          main_load = 1'b1;
          main_val = delay_total;
        end
      end
      MSS_DELAY: begin
        if (!power_enable_switch) begin
          state_nxt = MSS_OFF;
        end else if (main_expire) begin
          state_nxt = MSS_SKIP;
          main_load = 1'b1;
          main_val = {1'b0, skip_r};
        end
      end
      MSS_SKIP: begin
        if (!power_enable_switch) begin
          state_nxt = MSS_OFF;
        end else if (main_expire) begin
          state_nxt = MSS_IDLE;
        end
      end
      default: begin
        state_nxt = MSS_OFF;
      end
    endcase
  end

  mss_ms_timer #(
    .W(11)
  ) u_main_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .tick(tick_r),
    .load(main_load),
    .load_val(main_val),
    .busy(),
    .expire(main_expire)
  );

  // Lamp pulse length is fixed and runs to its end even if the switch is turned off
  mss_ms_timer #(
    .W(11)
  ) u_lamp_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .tick(tick_r),
    .load(start_cycle),
    .load_val(LAMP_MS),
    .busy(lamp_busy),
    .expire(lamp_expire)
  );

  // Millisecond tick
  // Shared by all timers, so each duration may come out up to one tick short
  wire tick_wrap = (tick_cnt_r == TW'(TICK_CYCLES - 1));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (ce) begin
      tick_cnt_r <= tick_wrap ? '0 : tick_cnt_r + TW'(1);
      tick_r <= tick_wrap;
    end
  end

  // Sequencer state and edge history
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= MSS_OFF;
      hit_prev_r <= 1'b0;
      man_prev_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      hit_prev_r <= pickup_threshold_hit;
      man_prev_r <= manual_trigger_switch;
    end
  end

  // Valve and lamps
  // Valve and skip lamp rise together one cycle after the delay expires
  wire skip_next = (state_nxt == MSS_SKIP);
  wire found_next = start_cycle || (lamp_busy && !lamp_expire && found_r);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      valve_r <= 1'b0;
      skip_lamp_r <= 1'b0;
      found_r <= 1'b0;
      fault_r <= 1'b0;
    end else if (ce) begin
      valve_r <= skip_next;
      skip_lamp_r <= skip_next;
      found_r <= found_next;
      fault_r <= sensor_fault;
    end
  end

  // Settings registers
  // Writes take the clamped values; nothing is refused
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      delay_r <= `MSS_DELAY_RST;
      trim_r <= `MSS_TRIM_RST;
      skip_r <= `MSS_SKIP_RST;
      thresh_r <= SW'(`MSS_THRESH_RST);
    end else if (ce) begin
      if (wr_delay) begin
        delay_r <= delay_wval;
      end
      if (wr_trim) begin
        trim_r <= trim_wval;
      end
      if (wr_skip) begin
        skip_r <= skip_wval;
      end
      if (wr_thresh) begin
        thresh_r <= reg_wdata[SW-1:0];
      end
    end
  end

  // Software trigger; consumed when the cycle starts or dropped when not idle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      soft_trig_r <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl && reg_wdata[`MSS_CTRL_SOFT_TRIG]) begin
        soft_trig_r <= 1'b1;
      end else begin
        soft_trig_r <= 1'b0;
      end
    end
  end

  // Event counters; a clearing write in the same cycle as a new event leaves the count at one
  wire det_inc = start_cycle && det_edge;
  wire skip_inc = (state_r == MSS_DELAY) && main_expire && power_enable_switch;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      det_cnt_r <= 16'h0000;
      skip_cnt_r <= 16'h0000;
    end else if (ce) begin
      if (det_inc) begin
        det_cnt_r <= wr_detcnt ? 16'h0001 : sat_inc(det_cnt_r);
      end else if (wr_detcnt) begin
        det_cnt_r <= 16'h0000;
      end
      if (skip_inc) begin
        skip_cnt_r <= wr_skipcnt ? 16'h0001 : sat_inc(skip_cnt_r);
      end else if (wr_skipcnt) begin
        skip_cnt_r <= 16'h0000;
      end
    end
  end

  // Read mux
  // Unmapped addresses and CTRL read as zero
  logic [31:0] status_word;
  logic [31:0] rd_mux;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`MSS_ST_STATE_LSB +: 3] = state_r;
    status_word[`MSS_ST_VALVE] = valve_r;
    status_word[`MSS_ST_FOUND] = found_r;
    status_word[`MSS_ST_SKIP] = skip_lamp_r;
    status_word[`MSS_ST_FAULT] = fault_r;
    status_word[`MSS_ST_ENABLE] = power_enable_switch;
  end

  assign rd_mux = sel_delay ? {22'h000000, delay_r} :
                  sel_trim ? {22'h000000, trim_r} :
                  sel_skip ? {22'h000000, skip_r} :
                  sel_thresh ? 32'(thresh_r) :
                  sel_status ? status_word :
                  sel_detcnt ? {16'h0000, det_cnt_r} :
                  sel_skipcnt ? {16'h0000, skip_cnt_r} :
                  32'h0000_0000;

  // Read data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (ce) begin
      rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_r;
  assign valve_drive = valve_r;
  assign marker_found_lamp = found_r;
  assign skip_lamp = skip_lamp_r;
  assign sensor_fault_lamp = fault_r;

endmodule

// >>> hdl/mss_cfg.svh
// Functional notes
// - Accepted detection starts delay_timer, programmable from zero to about half a second.
// - Separate speed_trim fine value is added to the coarse delay setting.
// - When delay_timer expires, skip_timer runs and valves are driven throughout it.
// - After switch-on, detections and triggers are ignored for a one-second warm-up.
// - While power_enable_switch is off, no skip cycle is started.
// - marker_found_lamp pulses for a fixed time when a detection starts delay_timer.
// - Skip lamp is lit exactly during the skip_timer interval, dark otherwise.
// - sensor_fault_lamp lights whenever the sensor front end reports a malfunction.
// - Closing the manual_trigger_switch performs a skip exactly like a detected marker.
// - All settings at maximum give about 3/4 s delay then about 1/2 s skip.
// - Programmable pickup_threshold sets sensor strength needed to count as detection.
// - Skip interval is never shorter than about 0.02 seconds.
`ifndef MSS_CFG_SVH
`define MSS_CFG_SVH

// Register offsets (byte addresses)
`define MSS_REG_DELAY 8'h00
`define MSS_REG_TRIM 8'h04
`define MSS_REG_SKIP 8'h08
`define MSS_REG_THRESH 8'h0C
`define MSS_REG_CTRL 8'h10
`define MSS_REG_STATUS 8'h14
`define MSS_REG_DETCNT 8'h18
`define MSS_REG_SKIPCNT 8'h1C

// Field positions
`define MSS_CTRL_SOFT_TRIG 0
`define MSS_ST_STATE_LSB 0
`define MSS_ST_VALVE 3
`define MSS_ST_FOUND 4
`define MSS_ST_SKIP 5
`define MSS_ST_FAULT 6
`define MSS_ST_ENABLE 7

// Reset values, milliseconds except the threshold, which is a sensor level
`define MSS_DELAY_RST 10'h000
`define MSS_TRIM_RST 10'h07D
`define MSS_SKIP_RST 10'h0FA
`define MSS_THRESH_RST 8'h80

// Setting limits, milliseconds
`define MSS_DELAY_MAX_MS 500
`define MSS_TRIM_MAX_MS 250
`define MSS_SKIP_MIN_MS 20
`define MSS_SKIP_MAX_MS 500

// Timing
`define MSS_CLK_PERIOD_NS 20
`define MSS_TICK_NS 1000000
`define MSS_TICK_CYCLES (`MSS_TICK_NS / `MSS_CLK_PERIOD_NS)
`define MSS_WARMUP_MS 1000
`define MSS_FOUND_LAMP_MS 50

`endif

// >>> hdl/mss_pkg.sv
package mss_pkg;
  typedef enum logic [2:0] {
    MSS_OFF,
    MSS_WARMUP,
    MSS_IDLE,
    MSS_DELAY,
    MSS_SKIP
  } mss_state_t;
endpackage

// >>> hdl/mss_ms_timer.sv
`timescale 1ns/1ps
// Millisecond down-counter; expire pulses once when the count runs out
module mss_ms_timer #(
  parameter int W = 10
) (
  // Clock and control
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic tick,
  // Load
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // Status
  output logic busy,
  output logic expire
);
  logic [W-1:0] count_r;
  logic expire_r;
  wire count_zero = (count_r == '0);
  wire count_last = (count_r == W'(1));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_r <= '0;
      expire_r <= 1'b0;
    end else if (ce) begin
      if (load) begin
        count_r <= load_val;
        expire_r <= (load_val == '0);
      end else if (tick && !count_zero) begin
        count_r <= count_r - W'(1);
        expire_r <= count_last;
      end else begin
        expire_r <= 1'b0;
      end
    end
  end

  assign busy = !count_zero;
  assign expire = expire_r;
endmodule

// >>> test/mss_sequencer_sva.sv
`timescale 1ns/1ps
module mss_sequencer_sva #(
  parameter int TICK_CYCLES = 50000,
  parameter int AW = 8,
  parameter int SW = 8
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Register port
  input wire logic [AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Sensor and switches
  input wire logic [SW-1:0] sensor_level,
  input wire logic sensor_fault,
  input wire logic power_enable_switch,
  input wire logic manual_trigger_switch,
  // Valve and lamps
  input wire logic valve_drive,
  input wire logic marker_found_lamp,
  input wire logic skip_lamp,
  input wire logic sensor_fault_lamp
);
  int fcnt;
  int vcnt;
  int wcnt;
  int dcnt;
  // Lamp and valve lengths, time since power on, time since cycle start
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fcnt <= 0;
      vcnt <= 0;
      wcnt <= 0;
      dcnt <= 0;
    end else begin
      fcnt <= marker_found_lamp ? fcnt + 1 : 0;
      vcnt <= valve_drive ? vcnt + 1 : 0;
      wcnt <= !power_enable_switch ? 0 : (wcnt < 1000000 ? wcnt + 1 : wcnt);
      dcnt <= (marker_found_lamp && fcnt == 0) ? 0 : dcnt + 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_lamp_valve_eq: assert property (skip_lamp == valve_drive)
    else $error("skip lamp differs from valve");
  a_fault_lamp_on: assert property (sensor_fault |=> sensor_fault_lamp)
    else $error("fault lamp not lit");
  a_off_no_valve: assert property (!power_enable_switch |=> !valve_drive)
    else $error("valve driven while off");
  a_found_from_idle: assert property ($rose(marker_found_lamp) |-> !valve_drive)
    else $error("cycle started during skip");
  a_warmup_quiet: assert property ($rose(marker_found_lamp) |-> wcnt >= 999 * TICK_CYCLES)
    else $error("detection during warm-up");
  a_found_pulse_len: assert property ($fell(marker_found_lamp) && power_enable_switch
    |-> fcnt inside {[49 * TICK_CYCLES:51 * TICK_CYCLES + 1]}) else $error("found lamp length");
  a_skip_min_len: assert property ($fell(valve_drive) && power_enable_switch
    |-> vcnt >= 19 * TICK_CYCLES) else $error("skip too short");
  a_skip_max_len: assert property (valve_drive |-> vcnt <= 501 * TICK_CYCLES)
    else $error("skip too long");
  a_delay_max_len: assert property ($rose(valve_drive) |-> dcnt <= 751 * TICK_CYCLES + 4)
    else $error("delay too long");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read slot");
endmodule

// >>> test/mss_sensor_model.sv
`timescale 1ns/1ps
module mss_sensor_model (
  // Requests from bench
  input wire logic clk,
  input wire logic pass_req,
  input wire logic [7:0] amp,
  input wire logic press,
  // Front end and remote switch
  output logic [7:0] sensor_level,
  output logic manual_trigger_switch
);
  int n = 0;
  int m = 0;
  // Plate pass holds its amplitude for 30 cycles, then a noise floor
  always_ff @(posedge clk) begin
    n <= pass_req ? 30 : (n > 0 ? n - 1 : 0);
    m <= press ? 40 : (m > 0 ? m - 1 : 0);
  end
  assign sensor_level = (n > 0) ? amp : 8'h05;
  assign manual_trigger_switch = m > 0;
endmodule

// >>> test/mss_sequencer_tb.sv
`timescale 1ns/1ps
`include "mss_cfg.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %0t got %0h exp %0h", $time, g, e); end end
module mss_sequencer_tb import mss_pkg::*;;
  localparam int T = 10;
  logic clk = 0;
  logic sys_rst = 1;
  logic ce = 1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [31:0] reg_rdata;
  logic [7:0] sensor_level;
  logic sensor_fault = 0;
  logic power_enable_switch = 1;
  logic manual_trigger_switch;
  logic valve_drive;
  logic marker_found_lamp;
  logic skip_lamp;
  logic sensor_fault_lamp;
  logic pass_req = 0;
  logic press = 0;
  logic [7:0] amp = 8'h00;
  int err_count = 0;
  int n_checks = 0;
  always #10 clk = ~clk;
  mss_sequencer #(.TICK_CYCLES(T)) uut (
    .clk(clk), .sys_rst(sys_rst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sensor_level(sensor_level), .sensor_fault(sensor_fault),
    .power_enable_switch(power_enable_switch), .manual_trigger_switch(manual_trigger_switch),
    .valve_drive(valve_drive), .marker_found_lamp(marker_found_lamp), .skip_lamp(skip_lamp),
    .sensor_fault_lamp(sensor_fault_lamp)
  );
  mss_sensor_model pm (
    .clk(clk), .pass_req(pass_req), .amp(amp), .press(press),
    .sensor_level(sensor_level), .manual_trigger_switch(manual_trigger_switch)
  );
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
    #1;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge clk);
    reg_rd <= 0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  task automatic hit(input logic [7:0] a);
    amp <= a;
    pass_req <= 1;
    @(posedge clk);
    pass_req <= 0;
    #1;
  endtask
  task automatic wait_n(input int k, input logic lvl);
    repeat (k) @(posedge clk);
    #1;
    `CHK(marker_found_lamp, lvl)
  endtask
  // One full cycle: found lamp, delay d ms, skip s ms, then settle; g cycles have passed since the trigger
  task automatic cyc(input int d, input int s, input int g);
    int n;
    n = g;
    while (valve_drive !== 1'b1 && n < 8000) begin
      @(posedge clk);
      n++;
    end
    `CHK(n >= d * T - T && n <= d * T + T + 4, 1'b1)
    if (n == 8000) complete_run();
    n = 0;
    while (valve_drive === 1'b1 && n < 6000) begin
      @(posedge clk);
      n++;
    end
    `CHK(n >= s * T - T && n <= s * T + T + 2, 1'b1)
    if (n == 6000) complete_run();
    repeat (600) @(posedge clk);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 0;
    rchk(`MSS_REG_DELAY, 32'h0);
    rchk(`MSS_REG_TRIM, 32'h7D);
    rchk(`MSS_REG_SKIP, 32'hFA);
    rchk(`MSS_REG_THRESH, 32'h80);
    rchk(8'h20, 32'h0);
    wr(`MSS_REG_SKIP, 32'h5);
    rchk(`MSS_REG_SKIP, 32'h14);
    wr(`MSS_REG_DELAY, 32'h384);
    rchk(`MSS_REG_DELAY, 32'h1F4);
    hit(8'hC0);
    wait_n(60, 1'b0);
    repeat (10100) @(posedge clk);
    $display("registers and warm-up done");
    wr(`MSS_REG_DELAY, 32'h5);
    wr(`MSS_REG_TRIM, 32'h0);
    wr(`MSS_REG_SKIP, 32'h14);
    hit(8'h90);
    repeat (35) @(posedge clk);
    hit(8'hC0);
    cyc(5, 20, 36);
    `CHK(marker_found_lamp, 1'b0)
    rchk(`MSS_REG_STATUS, 32'h82);
    rchk(`MSS_REG_DETCNT, 32'h1);
    rchk(`MSS_REG_SKIPCNT, 32'h1);
    $display("detection done");
    wr(`MSS_REG_THRESH, 32'hA0);
    wr(`MSS_REG_TRIM, 32'hA);
    hit(8'h90);
    wait_n(40, 1'b0);
    hit(8'hA0);
    cyc(15, 20, 0);
    sensor_fault <= 1;
    repeat (2) @(posedge clk);
    `CHK(sensor_fault_lamp, 1'b1)
    hit(8'hC0);
    wait_n(40, 1'b0);
    sensor_fault <= 0;
    repeat (2) @(posedge clk);
    `CHK(sensor_fault_lamp, 1'b0)
    $display("threshold and fault done");
    press <= 1;
    @(posedge clk);
    press <= 0;
    cyc(15, 20, 0);
    wr(`MSS_REG_CTRL, 32'h1);
    cyc(15, 20, 0);
    wr(`MSS_REG_DELAY, 32'h1F4);
    wr(`MSS_REG_TRIM, 32'hFA);
    wr(`MSS_REG_SKIP, 32'h1F4);
    hit(8'hC0);
    cyc(750, 500, 0);
    wr(`MSS_REG_DELAY, 32'h0);
    wr(`MSS_REG_TRIM, 32'h0);
    hit(8'hC0);
    cyc(0, 500, 0);
    $display("manual and range done");
    hit(8'hC0);
    repeat (600) @(posedge clk);
    `CHK(valve_drive, 1'b1)
    `CHK(skip_lamp, 1'b1)
    power_enable_switch <= 0;
    repeat (2) @(posedge clk);
    `CHK(valve_drive, 1'b0)
    `CHK(skip_lamp, 1'b0)
    hit(8'hC0);
    wait_n(40, 1'b0);
    power_enable_switch <= 1;
    hit(8'hC0);
    wait_n(40, 1'b0);
    $display("switch done");
    ce <= 0;
    wr(`MSS_REG_DELAY, 32'h5);
    ce <= 1;
    rchk(`MSS_REG_DELAY, 32'h0);
    $display("clock enable done");
    complete_run();
  end
endmodule
bind mss_sequencer mss_sequencer_sva #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .clk(clk), .sys_rst(sys_rst), .ce(ce),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sensor_level(sensor_level), .sensor_fault(sensor_fault),
  .power_enable_switch(power_enable_switch), .manual_trigger_switch(manual_trigger_switch),
  .valve_drive(valve_drive), .marker_found_lamp(marker_found_lamp), .skip_lamp(skip_lamp),
  .sensor_fault_lamp(sensor_fault_lamp)
);
